// ==== verilog/nvm_pkg.sv ====
// ==========================================================
// shared constants and types for the nvm access controller
package nvm_pkg;

  // register select codes on the i/o register port
  localparam logic [1:0] SEL_ADDR_LOW  = 2'h0;
  localparam logic [1:0] SEL_ADDR_HIGH = 2'h1;
  localparam logic [1:0] SEL_DATA      = 2'h2;
  localparam logic [1:0] SEL_CONTROL   = 2'h3;

  // control register field positions
  localparam int MODE_HI_POS   = 5;
  localparam int MODE_LO_POS   = 4;
  localparam int RIE_POS       = 3;
  localparam int ARM_POS       = 2;
  localparam int PSTROBE_POS   = 1;
  localparam int RSTROBE_POS   = 0;

  // programming modes
  typedef enum logic [1:0] {
    MODE_ATOMIC   = 2'h0,
    MODE_ERASE    = 2'h1,
    MODE_WRITE    = 2'h2,
    MODE_RESERVED = 2'h3
  } prog_mode_t;

  // control register image, bit 7 down to bit 0
  typedef struct packed {
    logic [1:0] zero;
    prog_mode_t mode;
    logic       ready_irq_enable;
    logic       master_program_arm;
    logic       program_strobe;
    logic       read_strobe;
  } nvm_ctrl_t;

  // values after reset
  localparam logic [7:0] DATA_RST   = 8'h00;
  localparam logic [8:0] ADDR_RST   = 9'h000;
  localparam prog_mode_t MODE_RST   = MODE_ATOMIC;

  // cpu-clock interlock and stall counts
  localparam logic [2:0] ARM_CYCLES        = 3'h4;
  localparam logic [2:0] READ_STALL_CYCLES = 3'h4;
  localparam logic [2:0] PROG_STALL_CYCLES = 3'h2;

  // programming times, timing oscillator in kHz
  localparam int OSC_KHZ       = 8000;
  localparam int ATOMIC_TIME_US = 3400;
  localparam int SPLIT_TIME_US  = 1800;
  localparam int ATOMIC_TICKS  = (ATOMIC_TIME_US * OSC_KHZ) / 1000;
  localparam int SPLIT_TICKS   = (SPLIT_TIME_US * OSC_KHZ) / 1000;

endpackage

// ==== verilog/down_timer.sv ====
`timescale 1ns/10ps
// ==========================================================
// loadable down counter, steps on tick
module down_timer #(
  parameter int W = 3
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         rstn,
  input  wire logic         ce,
  // control
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         tick,
  // status
  output logic              running,
  output logic              done
);

  logic [W-1:0] cnt_r;

  // count down to zero, load wins
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= '0;
    end else if (ce) begin
      if (load) begin
        cnt_r <= load_val;
      end else if (tick && cnt_r != '0) begin
        cnt_r <= cnt_r - W'(1);
      end
    end
  end

  assign running = (cnt_r != '0);
  assign done    = ce && !load && tick && (cnt_r == W'(1));

endmodule // down_timer

// ==== verilog/prog_engine.sv ====
`timescale 1ns/10ps
// ==========================================================
// programming timer kept alive across rstn, mode field kept across rstn only while busy
module prog_engine #(
  parameter int ATOMIC_TICKS = nvm_pkg::ATOMIC_TICKS,
  parameter int SPLIT_TICKS  = nvm_pkg::SPLIT_TICKS,
  parameter int TW           = 16
) (
  // clock and resets
  input  wire logic               core_clk,
  input  wire logic               por_n,
  input  wire logic               rstn,
  input  wire logic               ce,
  input  wire logic               osc_tick,
  // requests
  input  wire logic               mode_wr,
  input  wire nvm_pkg::prog_mode_t mode_wdata,
  input  wire logic               start,
  // status
  output nvm_pkg::prog_mode_t     mode,
  output logic                    busy,
  output logic                    done
);

  nvm_pkg::prog_mode_t mode_r;
  logic [TW-1:0]       dur;

  // duration by mode, taken from the mode being started
  always_comb begin
    if (mode_wdata == nvm_pkg::MODE_ATOMIC) begin
      dur = TW'(ATOMIC_TICKS);
    end else begin
      dur = TW'(SPLIT_TICKS);
    end
  end

  down_timer #(.W(TW)) u_prog_tmr (
    .core_clk (core_clk),
    .rstn     (por_n),
    .ce       (ce),
    .load     (start),
    .load_val (dur),
    .tick     (osc_tick),
    .running  (busy),
    .done     (done)
  );

  // mode write blocked while busy, cleared in reset if idle
  always_ff @(posedge core_clk or negedge por_n) begin
    if (!por_n) begin
      mode_r <= nvm_pkg::MODE_RST;
    end else if (ce) begin
      if (!rstn && !busy) begin
        mode_r <= nvm_pkg::MODE_RST;
      end else if (rstn && mode_wr && !busy) begin
        mode_r <= mode_wdata;
      end
    end
  end

  assign mode = mode_r;

endmodule // prog_engine

// ==== verilog/nvm_access_ctrl.sv ====
`timescale 1ns/10ps
// ==========================================================
module nvm_access_ctrl #(
  parameter int ATOMIC_TICKS = nvm_pkg::ATOMIC_TICKS,
  parameter int SPLIT_TICKS  = nvm_pkg::SPLIT_TICKS
) (
  // clock, resets, enable
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        por_n,
  input  wire logic        ce,
  // timing oscillator tick, one core_clk cycle wide
  input  wire logic        osc_tick,
  // i/o register port
  input  wire logic [1:0]  io_sel,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata,
  // cpu side
  input  wire logic        global_irq_enable,
  output logic             cpu_stall,
  output logic             irq_ready,
  // nvm array side
  output logic      [8:0]  arr_addr,
  output logic      [7:0]  arr_wdata,
  output logic             arr_rd,
  input  wire logic [7:0]  arr_rdata,
  output logic             arr_start,
  output nvm_pkg::prog_mode_t arr_mode,
  output logic             arr_busy
);

  // ==========================================================
  // state
  logic [8:0]          nvm_byte_address_r;
  logic [7:0]          nvm_data_r;
  logic [7:0]          wdata_lat_r;
  logic [8:0]          addr_lat_r;
  logic                ready_irq_enable_r;
  logic [7:0]          rdata_r;
  nvm_pkg::nvm_ctrl_t  wr_ctrl;
  nvm_pkg::nvm_ctrl_t  rd_ctrl;
  nvm_pkg::prog_mode_t prog_mode_field;
  logic                ctrl_wr;
  logic                arm_live;
  logic                prog_busy;
  logic                prog_done;
  logic                start_req;
  logic                read_req;
  logic                stall_load;
  logic [2:0]          stall_val;

  assign wr_ctrl = nvm_pkg::nvm_ctrl_t'(io_wdata);
  assign ctrl_wr = io_wr && (io_sel == nvm_pkg::SEL_CONTROL);

  // ==========================================================
  // arming interlock
  // four-cycle arm window
  down_timer #(.W(3)) u_arm_tmr (
    .core_clk (core_clk),
    .rstn     (rstn),
    .ce       (ce),
    .load     (ctrl_wr && wr_ctrl.master_program_arm),
    .load_val (nvm_pkg::ARM_CYCLES),
    .tick     (1'b1),
    .running  (arm_live),
    .done     ()
  );

  // start only while armed, idle, legal mode
  assign start_req = ctrl_wr && wr_ctrl.program_strobe && arm_live
                     && !prog_busy
                     && (wr_ctrl.mode != nvm_pkg::MODE_RESERVED);
  assign read_req  = ctrl_wr && wr_ctrl.read_strobe && !prog_busy;

  // ==========================================================
  // programming engine
  // mode selects configurable duration
  prog_engine #(
    .ATOMIC_TICKS (ATOMIC_TICKS),
    .SPLIT_TICKS  (SPLIT_TICKS),
    .TW           (16)
  ) u_engine (
    .core_clk   (core_clk),
    .por_n      (por_n),
    .rstn       (rstn),
    .ce         (ce),
    .osc_tick   (osc_tick),
    .mode_wr    (ctrl_wr),
    .mode_wdata (wr_ctrl.mode),
    .start      (start_req),
    .mode       (prog_mode_field),
    .busy       (prog_busy),
    .done       (prog_done)
  );

  // ==========================================================
  // cpu stall
  // stall two cycles after program, four after read
  assign stall_load = start_req || read_req;
  assign stall_val  = start_req ? nvm_pkg::PROG_STALL_CYCLES
                                : nvm_pkg::READ_STALL_CYCLES;

  down_timer #(.W(3)) u_stall_tmr (
    .core_clk (core_clk),
    .rstn     (rstn),
    .ce       (ce),
    .load     (stall_load),
    .load_val (stall_val),
    .tick     (1'b1),
    .running  (cpu_stall),
    .done     ()
  );

  // ==========================================================
  // address register
  // nine bits, frozen while busy
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      nvm_byte_address_r <= nvm_pkg::ADDR_RST;
    end else if (ce && io_wr && !prog_busy) begin
      if (io_sel == nvm_pkg::SEL_ADDR_LOW) begin
        nvm_byte_address_r[7:0] <= io_wdata;
      end else if (io_sel == nvm_pkg::SEL_ADDR_HIGH) begin
        nvm_byte_address_r[8] <= io_wdata[0];
      end
    end
  end

  // ==========================================================
  // data register
  // fetched byte lands in the read instruction
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      nvm_data_r <= nvm_pkg::DATA_RST;
    end else if (ce) begin
      if (read_req) begin
        nvm_data_r <= arr_rdata;
      end else if (io_wr && io_sel == nvm_pkg::SEL_DATA) begin
        nvm_data_r <= io_wdata;
      end
    end
  end

  // byte to program latched at start
  // kept on por_n so a system reset cannot spoil a running job
  always_ff @(posedge core_clk or negedge por_n) begin
    if (!por_n) begin
      wdata_lat_r <= nvm_pkg::DATA_RST;
    end else if (ce && start_req) begin
      wdata_lat_r <= nvm_data_r;
    end
  end

  // ==========================================================
  // programming target address
  // target address latched at start, survives rstn
  always_ff @(posedge core_clk or negedge por_n) begin
    if (!por_n) begin
      addr_lat_r <= nvm_pkg::ADDR_RST;
    end else if (ce && start_req) begin
      addr_lat_r <= nvm_byte_address_r;
    end
  end

  // ==========================================================
  // interrupt enable
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ready_irq_enable_r <= 1'b0;
    end else if (ce && ctrl_wr) begin
      ready_irq_enable_r <= wr_ctrl.ready_irq_enable;
    end
  end

  // level request while enabled and idle
  assign irq_ready = ready_irq_enable_r && global_irq_enable
                     && !prog_busy;

  // ==========================================================
  // readback
  // control image, top bits zero
  always_comb begin
    rd_ctrl                    = '0;
    rd_ctrl.mode               = prog_mode_field;
    rd_ctrl.ready_irq_enable   = ready_irq_enable_r;
    rd_ctrl.master_program_arm = arm_live;
    rd_ctrl.program_strobe     = prog_busy;
  end

  // registered read data, one cycle after io_rd
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= 8'h00;
    end else if (ce && io_rd) begin
      unique case (io_sel)
        nvm_pkg::SEL_ADDR_LOW:  rdata_r <= nvm_byte_address_r[7:0];
        nvm_pkg::SEL_ADDR_HIGH: rdata_r <= {7'h00, nvm_byte_address_r[8]};
        nvm_pkg::SEL_DATA:      rdata_r <= nvm_data_r;
        nvm_pkg::SEL_CONTROL:   rdata_r <= 8'(rd_ctrl);
      endcase
    end
  end

  assign io_rdata = rdata_r;

  // ==========================================================
  // array side
  // unerased write content is left to the array
  // reads use the live address, programming the latched one
  assign arr_addr  = arr_rd ? nvm_byte_address_r : addr_lat_r;
  assign arr_wdata = wdata_lat_r;
  assign arr_rd    = read_req && ce;
  assign arr_start = start_req && ce;
  assign arr_mode  = prog_mode_field;
  assign arr_busy  = prog_busy;

  // ==========================================================
  // assertions
  a_arm_expires: assert property (@(posedge core_clk) disable iff (!rstn)
    (ce && ctrl_wr && wr_ctrl.master_program_arm) ##1 ce [*5]
      |-> !arm_live)
    else $error("arm bit not cleared after four cycles");

  a_arm_holds: assert property (@(posedge core_clk) disable iff (!rstn)
    (ce && ctrl_wr && wr_ctrl.master_program_arm) |=> arm_live)
    else $error("arm bit not set after write");

  a_start_armed: assert property (@(posedge core_clk) disable iff (!rstn)
    arr_start |-> arm_live && !prog_busy)
    else $error("programming started without arm");

  a_start_busy: assert property (@(posedge core_clk) disable iff (!rstn)
    arr_start |=> prog_busy)
    else $error("strobe not held after start");

  a_mode_frozen: assert property (@(posedge core_clk) disable iff (!rstn)
    prog_busy && $past(prog_busy) |-> $stable(prog_mode_field))
    else $error("mode changed while programming");

  a_addr_frozen: assert property (@(posedge core_clk) disable iff (!rstn)
    $past(prog_busy) |-> $stable(nvm_byte_address_r))
    else $error("address changed while programming");

  a_no_busy_read: assert property (@(posedge core_clk) disable iff (!rstn)
    prog_busy |-> !arr_rd)
    else $error("read issued while programming");

  a_read_stall: assert property (@(posedge core_clk) disable iff (!rstn)
    (read_req && ce) ##1 ce [*4] |-> cpu_stall ##1 !cpu_stall)
    else $error("read stall length wrong");

  a_prog_stall: assert property (@(posedge core_clk) disable iff (!rstn)
    (start_req && ce) ##1 ce [*2] |-> cpu_stall ##1 !cpu_stall)
    else $error("program stall not two cycles");

  a_read_data: assert property (@(posedge core_clk) disable iff (!rstn)
    (read_req && ce) |=> nvm_data_r == $past(arr_rdata))
    else $error("read byte not captured");

  a_irq_level: assert property (@(posedge core_clk) disable iff (!rstn)
    irq_ready == (ready_irq_enable_r && global_irq_enable && !prog_busy))
    else $error("ready interrupt level wrong");

  a_ctrl_top: assert property (@(posedge core_clk) disable iff (!rstn)
    $past(io_rd && ce && io_sel == nvm_pkg::SEL_CONTROL)
      |-> io_rdata[7:6] == 2'h0)
    else $error("control top bits not zero");

  a_high_zero: assert property (@(posedge core_clk) disable iff (!rstn)
    $past(io_rd && ce && io_sel == nvm_pkg::SEL_ADDR_HIGH)
      |-> io_rdata[7:1] == 7'h00)
    else $error("address high unused bits not zero");

  a_strobe_readback: assert property (@(posedge core_clk) disable iff (!rstn)
    $past(io_rd && ce && io_sel == nvm_pkg::SEL_CONTROL)
      |-> io_rdata[1] == $past(prog_busy))
    else $error("strobe bit does not follow busy");

  a_strobe_clear: assert property (@(posedge core_clk) disable iff (!rstn)
    $fell(prog_busy) |-> $past(prog_done))
    else $error("strobe cleared before completion");

  a_reserved_mode: assert property (@(posedge core_clk) disable iff (!rstn)
    (ctrl_wr && wr_ctrl.mode == nvm_pkg::MODE_RESERVED) |-> !arr_start)
    else $error("reserved mode started programming");

  a_mode_write: assert property (@(posedge core_clk) disable iff (!rstn)
    (ce && ctrl_wr && !prog_busy) |=> prog_mode_field == $past(wr_ctrl.mode))
    else $error("mode not written while idle");

  a_data_write: assert property (@(posedge core_clk) disable iff (!rstn)
    (ce && io_wr && io_sel == nvm_pkg::SEL_DATA)
      |=> nvm_data_r == $past(io_wdata))
    else $error("data register write lost");

  a_target_latch: assert property (@(posedge core_clk) disable iff (!rstn)
    arr_start |=> addr_lat_r == $past(nvm_byte_address_r))
    else $error("target address not latched at start");

  a_start_stall: assert property (@(posedge core_clk) disable iff (!rstn)
    arr_start |=> cpu_stall)
    else $error("no stall after program start");

  a_read_stall_on: assert property (@(posedge core_clk) disable iff (!rstn)
    arr_rd |=> cpu_stall)
    else $error("no stall after read");

  c_atomic: cover property (@(posedge core_clk) disable iff (!rstn)
    arr_start && prog_mode_field == nvm_pkg::MODE_ATOMIC);
  c_erase: cover property (@(posedge core_clk) disable iff (!rstn)
    arr_start && wr_ctrl.mode == nvm_pkg::MODE_ERASE);
  c_write: cover property (@(posedge core_clk) disable iff (!rstn)
    arr_start && wr_ctrl.mode == nvm_pkg::MODE_WRITE);
  c_read: cover property (@(posedge core_clk) disable iff (!rstn)
    arr_rd);
  c_done: cover property (@(posedge core_clk) disable iff (!rstn)
    prog_done);

endmodule // nvm_access_ctrl

// ==== tb/nvm_array_model.sv ====
`timescale 1ns/10ps
// ==========================================================
// byte array behind the controller, 512 bytes, erased state ff
module nvm_array_model (
  // clock
  input  wire logic                core_clk,
  // controller side
  input  wire logic [8:0]          arr_addr,
  input  wire logic [7:0]          arr_wdata,
  input  wire logic                arr_rd,
  input  wire nvm_pkg::prog_mode_t arr_mode,
  input  wire logic                arr_busy,
  output logic      [7:0]          arr_rdata
);
  logic [7:0] mem [512];
  logic       busy_d;

  // erased array at start
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
    busy_d = 1'b0;
  end

  // linear byte address
  // outside a read the bus shows the inverted byte
  assign arr_rdata = arr_rd ? mem[arr_addr] : ~mem[arr_addr];

  // apply the selected action when busy ends
  always @(posedge core_clk) begin
    busy_d <= arr_busy;
    if (busy_d && !arr_busy) begin
      case (arr_mode)
        nvm_pkg::MODE_ERASE: mem[arr_addr] <= 8'hFF;
        nvm_pkg::MODE_WRITE: mem[arr_addr] <= mem[arr_addr] & arr_wdata;
        default:             mem[arr_addr] <= arr_wdata;
      endcase
    end
  end
endmodule // nvm_array_model

// ==== tb/eeprom_access_control_bench.sv ====
`timescale 1ns/10ps
`define CHK(got, exp) begin \
  comparisons++; \
  if ((got) !== (exp)) begin \
    error_cnt++; \
    $display("wrong value at %0t: got %h exp %h", $time, got, exp); \
  end \
end
// ==========================================================
// self-checking bench for the nvm access controller
module eeprom_access_control_bench;
  logic                core_clk, rstn, por_n, ce, osc_tick;
  logic [1:0]          io_sel;
  logic                io_wr, io_rd, global_irq_enable;
  logic [7:0]          io_wdata, io_rdata, arr_rdata, arr_wdata;
  logic                cpu_stall, irq_ready, arr_rd, arr_start, arr_busy;
  logic [8:0]          arr_addr;
  nvm_pkg::prog_mode_t arr_mode;
  logic [1:0]          tick_cnt;
  int                  error_cnt, comparisons;

  nvm_access_ctrl #(.ATOMIC_TICKS(20), .SPLIT_TICKS(10)) dut (
    .core_clk, .rstn, .por_n, .ce, .osc_tick, .io_sel, .io_wr,
    .io_rd, .io_wdata, .io_rdata, .global_irq_enable, .cpu_stall,
    .irq_ready, .arr_addr, .arr_wdata, .arr_rd, .arr_rdata,
    .arr_start, .arr_mode, .arr_busy);

  nvm_array_model array (
    .core_clk, .arr_addr, .arr_wdata, .arr_rd, .arr_mode,
    .arr_busy, .arr_rdata);

  // ==========================================================
  // clock and oscillator tick, one tick every four cycles
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  always @(negedge core_clk) begin
    tick_cnt <= tick_cnt + 2'h1;
    osc_tick <= (tick_cnt == 2'h3);
  end

  // ==========================================================
  // bus tasks, one transfer taken per call by wr and chk_rd; wait_idle polls arr_busy
  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    @(negedge core_clk);
    io_sel = s;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge core_clk);
    io_wr = 1'b0;
  endtask

  task automatic chk_rd(input logic [1:0] s, input logic [7:0] exp);
    @(negedge core_clk);
    io_sel = s;
    io_rd = 1'b1;
    @(negedge core_clk);
    io_rd = 1'b0;
    `CHK(io_rdata, exp)
  endtask

  task automatic wait_idle(output int n);
    n = 0;
    while (arr_busy !== 1'b0 && n < 1000) begin
      @(negedge core_clk);
      n++;
    end
  endtask

  // ==========================================================
  // scenarios
  // address loaded here before any array access
  task automatic t_reset_values;
    chk_rd(nvm_pkg::SEL_DATA, 8'h00);
    chk_rd(nvm_pkg::SEL_CONTROL, 8'h00);
    wr(nvm_pkg::SEL_ADDR_HIGH, 8'hFF);
    chk_rd(nvm_pkg::SEL_ADDR_HIGH, 8'h01);
    wr(nvm_pkg::SEL_ADDR_LOW, 8'h35);
    chk_rd(nvm_pkg::SEL_ADDR_LOW, 8'h35);
    $display("test reset_values done");
  endtask

  task automatic t_arm;
    wr(nvm_pkg::SEL_CONTROL, 8'h04);
    chk_rd(nvm_pkg::SEL_CONTROL, 8'h04);
    chk_rd(nvm_pkg::SEL_CONTROL, 8'h04);
    chk_rd(nvm_pkg::SEL_CONTROL, 8'h00);
    $display("test arm done");
  endtask

  // arm, wait gap cycles, strobe; go says whether it must start
  task automatic prog(input logic [1:0] m, input logic [7:0] d,
                      input int gap, input logic go, input int tk);
    int n;
    wr(nvm_pkg::SEL_DATA, d);
    wr(nvm_pkg::SEL_CONTROL, {2'b00, m, 4'b1100});
    repeat (gap) @(negedge core_clk);
    wr(nvm_pkg::SEL_CONTROL, {2'b00, m, 4'b1010});
    `CHK(arr_busy, go)
    `CHK(cpu_stall, go)
    if (go) begin
      @(negedge core_clk);
      `CHK(cpu_stall, 1'b1)
      @(negedge core_clk);
      `CHK(cpu_stall, 1'b0)
      wr(nvm_pkg::SEL_CONTROL, {2'b00, ~m, 4'b1001});
      `CHK(cpu_stall, 1'b0)
      wr(nvm_pkg::SEL_ADDR_LOW, 8'h00);
      `CHK(irq_ready, 1'b0)
      // arr_busy polled idle before the next read
      wait_idle(n);
      `CHK(n inside {[tk*4-12:tk*4+4]}, 1'b1)
      `CHK(irq_ready, 1'b1)
      chk_rd(nvm_pkg::SEL_CONTROL, {2'b00, m, 4'b1000});
      chk_rd(nvm_pkg::SEL_ADDR_LOW, 8'h35);
    end
    $display("test prog mode %0d done", m);
  endtask

  task automatic rdback(input logic [7:0] exp);
    wr(nvm_pkg::SEL_CONTROL, 8'h09);
    `CHK(cpu_stall, 1'b1)
    repeat (3) begin
      @(negedge core_clk);
      `CHK(cpu_stall, 1'b1)
    end
    @(negedge core_clk);
    `CHK(cpu_stall, 1'b0)
    chk_rd(nvm_pkg::SEL_DATA, exp);
    $display("test read back done");
  endtask

  task automatic t_irq;
    // top bits always written as zero
    wr(nvm_pkg::SEL_CONTROL, 8'h08);
    `CHK(irq_ready, 1'b1)
    chk_rd(nvm_pkg::SEL_CONTROL, 8'h08);
    global_irq_enable = 1'b0;
    @(negedge core_clk);
    `CHK(irq_ready, 1'b0)
    global_irq_enable = 1'b1;
    wr(nvm_pkg::SEL_CONTROL, 8'h00);
    `CHK(irq_ready, 1'b0)
    $display("test irq done");
  endtask

  task automatic t_reset_busy;
    int n;
    wr(nvm_pkg::SEL_CONTROL, 8'h14);
    wr(nvm_pkg::SEL_CONTROL, 8'h12);
    rstn = 1'b0;
    repeat (2) @(negedge core_clk);
    rstn = 1'b1;
    chk_rd(nvm_pkg::SEL_CONTROL, 8'h12);
    wait_idle(n);
    `CHK(n < 1000, 1'b1)
    chk_rd(nvm_pkg::SEL_CONTROL, 8'h10);
    rstn = 1'b0;
    repeat (2) @(negedge core_clk);
    rstn = 1'b1;
    chk_rd(nvm_pkg::SEL_CONTROL, 8'h00);
    $display("test reset_busy done");
  endtask

  // ==========================================================
  // verdict, reached from the main sequence or the watchdog
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // main sequence, inputs change at falling edges
  initial begin
    {rstn, por_n, io_wr, io_rd, osc_tick} = 5'h00;
    {ce, global_irq_enable} = 2'h3;
    {io_sel, io_wdata, tick_cnt} = 12'h000;
    error_cnt = 0;
    comparisons = 0;
    repeat (4) @(negedge core_clk);
    {rstn, por_n} = 2'h3;
    t_reset_values();
    t_arm();
    prog(nvm_pkg::MODE_ATOMIC, 8'hA5, 2, 1'b1, 20);
    rdback(8'hA5);
    prog(nvm_pkg::MODE_ERASE, 8'h00, 0, 1'b1, 10);
    rdback(8'hFF);
    prog(nvm_pkg::MODE_WRITE, 8'h3C, 0, 1'b1, 10);
    rdback(8'h3C);
    prog(nvm_pkg::MODE_RESERVED, 8'h00, 0, 1'b0, 0);
    prog(nvm_pkg::MODE_ATOMIC, 8'h11, 3, 1'b0, 0);
    rdback(8'h3C);
    t_irq();
    t_reset_busy();
    print_verdict();
  end

  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    print_verdict();
  end
endmodule // eeprom_access_control_bench
